/* common/rct_pkg.sv */
package rct_pkg;

  // clock and time base
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DELAY_MS = 72;
  localparam int DELAY_TICKS_DEF = DELAY_MS * 1000000 / TICK_NS;
  localparam int OSC_WAIT_CYCLES = 1024;

  // widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int RD_W = 16;
  localparam int PC_W = 13;
  localparam int TICK_W = 8;
  localparam int DELAY_W = 17;
  localparam int OSC_WAIT_W = 11;
  localparam int PIN_N = 3;

  // one-hot reset cause positions
  localparam int CAUSE_W = 7;
  localparam int C_POR = 0;
  localparam int C_DIP = 1;
  localparam int C_CLR_RUN = 2;
  localparam int C_CLR_SLEEP = 3;
  localparam int C_DOG_RST = 4;
  localparam int C_DOG_WAKE = 5;
  localparam int C_INT_WAKE = 6;

  // synchronised pin slots
  localparam int P_CLR = 0;
  localparam int P_SUPPLY_LOW = 1;
  localparam int P_OSC = 2;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_POWER = 8'h8E;
  localparam logic [7:0] IDX_CONFIG = 8'hC0;
  localparam logic [7:0] IDX_SEQ = 8'hC1;
  localparam logic [7:0] IDX_PCVAL = 8'hC2;

  // field positions
  localparam int ST_TIMEOUT_BIT = 4;
  localparam int ST_SLEEP_BIT = 3;
  localparam logic [7:0] ST_SW_MASK = 8'hE7;
  localparam int PWR_DIP_BIT = 0;
  localparam int PWR_POR_BIT = 1;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_DLY_BIT = 2;
  localparam int CFG_MON_BIT = 3;
  localparam logic [7:0] CFG_IMPL = 8'h0F;
  localparam logic [7:0] CFG_RESET = 8'h09;
  localparam int IRQ_EN_BIT = 7;

  // program counter values
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

  // oscillator modes
  typedef enum logic [1:0] {
    OSC_SLOW = 2'b00,
    OSC_XTAL = 2'b01,
    OSC_FAST = 2'b10,
    OSC_RC = 2'b11
  } rct_osc_e;

  // status load per cause: forced bits and their values
  localparam logic [7:0] ST_FMASK [CAUSE_W] = '{8'hF8, 8'hF8, 8'hE0, 8'hF8, 8'hF8, 8'h18, 8'h18};
  localparam logic [7:0] ST_FVAL [CAUSE_W] = '{8'h18, 8'h18, 8'h00, 8'h10, 8'h08, 8'h00, 8'h10};

  // default-loaded registers: pclath intcon cmcon option trisa trisb vrcon, data memory interface
  localparam int NDEF = 8;
  localparam int DEF_IRQ_SLOT = 1;
  localparam logic [7:0] DEF_IDX [NDEF] = '{8'h0A, 8'h0B, 8'h1F, 8'h81, 8'h85, 8'h86, 8'h9F, 8'h90};
  localparam logic [7:0] DEF_IMPL [NDEF] = '{8'h1F, 8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'hEF, 8'hFF};
  localparam logic [7:0] DEF_LMASK [NDEF] = '{8'h1F, 8'hFE, 8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'hEF, 8'h07};
  localparam logic [7:0] DEF_LVAL [NDEF] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h1F, 8'hFF, 8'h00, 8'h07};
  localparam logic [NDEF-1:0] DEF_ON_WAKE = 8'h80;

endpackage : rct_pkg

/* rtl/rct_reset_reg.sv */
`timescale 1ns/1ps
module rct_reset_reg #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] LMASK = 8'hFF,
  parameter logic [7:0] LVAL = 8'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sw_write,
  input wire logic [rct_pkg::REG_W-1:0] sw_wdata,
  input wire logic load,
  input wire logic [rct_pkg::REG_W-1:0] set_bits,
  output logic [rct_pkg::REG_W-1:0] q
);
  import rct_pkg::*;

  // value after load or software write, before hardware sets
  logic [REG_W-1:0] next_q;

  // load forces its masked bits, otherwise software may write
  always_comb begin
    next_q = q;
    if (load) begin
      next_q = (q & ~LMASK) | (LVAL & LMASK);
    end else if (sw_write) begin
      next_q = sw_wdata;
    end
  end

  // hardware set bits win over any clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      q <= LVAL & IMPL;
    end else begin
      q <= (next_q | set_bits) & IMPL;
    end
  end

endmodule : rct_reset_reg

/* rtl/rct_reset_cause.sv */
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
// What this block does
// - power control register holds two flags
// - brown-out clears dip flag, others keep
// - dip flag meaningless when monitor disabled
// - power-on clears power-on flag only
// - crystal modes: timer plus 1024 cycles
// - rc mode: timer only, wake undelayed
// - power-on sets timeout and sleep flags
// - status flags encode the reset cause
// - reset loads 000h, wake continues, vector
// - status load values per cause
// - resets load defaults, wake keeps all but data memory if
// - data memory if low bits forced 111
// - interrupt wake keeps causing flags set
// - unimplemented bits read as zero
// - power-on takes precedence over brown-out
// - power-up timer first, then oscillator timer
// - brown-out holds, timer restarts on dip
// - timeouts ignore master clear, release immediate
module rct_reset_cause #(
  parameter int DELAY_TICKS = rct_pkg::DELAY_TICKS_DEF
) (
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [rct_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rct_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [rct_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // cause vector and core side
  input wire logic [rct_pkg::CAUSE_W-1:0] cause_onehot,
  input wire logic [rct_pkg::REG_W-1:0] wake_irq_flags,
  input wire logic [rct_pkg::PC_W-1:0] pc_current,
  input wire logic instr_step,
  // pins from outside the clock domain
  input wire logic master_clear_n,
  input wire logic supply_low,
  input wire logic osc_clk_in,
  // outputs
  output logic core_reset,
  output logic pc_load,
  output logic [rct_pkg::PC_W-1:0] pc_load_value,
  output logic vector_pending
);
  import rct_pkg::*;

  // sequencer states, gray along hold-delay-osc wait-release-run
  typedef enum logic [2:0] {
    S_HOLD = 3'b000,
    S_PUP_WAIT = 3'b001,
    S_OSC_WAIT = 3'b011,
    S_RELEASE = 3'b010,
    S_RUN = 3'b110
  } rct_state_e;

  // address hit on a register index
  function automatic logic rct_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    rct_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : rct_hit

  // clean cause vector: power-on masks everything else
  function automatic logic [CAUSE_W-1:0] rct_pick(input logic [CAUSE_W-1:0] raw, input logic mon_en);
    logic [CAUSE_W-1:0] res;
    res = raw;
    res[C_DIP] = raw[C_DIP] & mon_en;
    if (raw[C_POR]) begin
      res = '0;
      res[C_POR] = 1'b1;
    end
    rct_pick = res;
  endfunction : rct_pick

  // pin synchronisers, stage a read only by stage b
  logic [PIN_N-1:0] sync_a;
  logic [PIN_N-1:0] sync_b;
  logic osc_prev;
  logic osc_edge;
  logic clear_s;
  logic supply_low_s;

  // bus state
  logic ack;
  logic wr_go;
  logic rd_take;
  logic [RD_W-1:0] rd_mux;

  // registers
  logic [REG_W-1:0] status_flags;
  logic [1:0] power_reset_cause;
  logic [REG_W-1:0] cfg;
  logic [REG_W-1:0] def_q [NDEF];

  // sequencer
  rct_state_e state;
  logic hold_is_dip;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [DELAY_W-1:0] pup_cnt;
  logic [OSC_WAIT_W-1:0] osc_cnt;

  // decoded causes
  logic [CAUSE_W-1:0] cause;
  logic any_reset;
  logic any_wake;
  logic crystal;
  rct_osc_e osc_mode;

  // two flops per pin before any logic looks at it
  always_ff @(posedge clock) begin
    if (rst) begin
      // supply counts as low until the pin has been seen, no false release
      sync_a <= PIN_N'(1 << P_SUPPLY_LOW);
      sync_b <= PIN_N'(1 << P_SUPPLY_LOW);
      osc_prev <= 1'b0;
    end else begin
      sync_a <= {osc_clk_in, supply_low, master_clear_n};
      sync_b <= sync_a;
      osc_prev <= sync_b[P_OSC];
    end
  end

  assign clear_s = sync_b[P_CLR];
  assign supply_low_s = sync_b[P_SUPPLY_LOW];
  assign osc_edge = sync_b[P_OSC] & ~osc_prev;

  assign cause = rct_pick(cause_onehot, cfg[CFG_MON_BIT]);
  assign any_reset = |cause[C_DOG_RST:C_POR];
  assign any_wake = cause[C_DOG_WAKE] | cause[C_INT_WAKE];
  assign osc_mode = rct_osc_e'(cfg[CFG_OSC_LSB +: 2]);
  assign crystal = (osc_mode != OSC_RC);

  // one wait state: request taken on the edge where ack is high
  always_ff @(posedge clock) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack & avs_byteenable[0];
  assign rd_take = avs_read & ~ack;

  // read mux, unimplemented and unmapped bits read zero
  always_comb begin
    rd_mux = '0;
    if (rct_hit(avs_address, IDX_STATUS)) begin
      rd_mux = {8'h00, status_flags};
    end
    if (rct_hit(avs_address, IDX_POWER)) begin
      rd_mux = {14'h0000, power_reset_cause};
    end
    if (rct_hit(avs_address, IDX_CONFIG)) begin
      rd_mux = {8'h00, cfg};
    end
    if (rct_hit(avs_address, IDX_SEQ)) begin
      rd_mux = {11'h000, vector_pending, core_reset, state};
    end
    if (rct_hit(avs_address, IDX_PCVAL)) begin
      rd_mux = {3'b000, pc_load_value};
    end
    for (int i = 0; i < NDEF; i++) begin
      if (rct_hit(avs_address, DEF_IDX[i])) begin
        rd_mux = {8'h00, def_q[i]};
      end
    end
  end

  // read data captured so it stands at the ack edge
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      avs_readdata <= {16'h0000, rd_mux};
    end
  end

  // configuration: oscillator mode, delay off, monitor enable
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= CFG_RESET;
    end else if (wr_go && rct_hit(avs_address, IDX_CONFIG)) begin
      cfg <= avs_writedata[REG_W-1:0] & CFG_IMPL;
    end
  end

  // status flags: software writes, cause loads override
  always_ff @(posedge clock) begin
    if (rst) begin
      status_flags <= ST_FVAL[C_POR];
    end else begin
      if (|cause) begin
        for (int i = 0; i < CAUSE_W; i++) begin
          if (cause[i]) begin
            status_flags <= (status_flags & ~ST_FMASK[i]) | (ST_FVAL[i] & ST_FMASK[i]);
          end
        end
      end else if (wr_go && rct_hit(avs_address, IDX_STATUS)) begin
        status_flags <= (status_flags & ~ST_SW_MASK) | (avs_writedata[REG_W-1:0] & ST_SW_MASK);
      end
    end
  end

  // two flags, hardware clear wins over software write
  always_ff @(posedge clock) begin
    if (rst) begin
      power_reset_cause <= 2'b00;
    end else begin
      if (wr_go && rct_hit(avs_address, IDX_POWER)) begin
        power_reset_cause <= avs_writedata[1:0];
      end
      if (cause[C_POR]) begin
        power_reset_cause[PWR_POR_BIT] <= 1'b0;
      end
      if (cause[C_DIP]) begin
        power_reset_cause[PWR_DIP_BIT] <= 1'b0;
      end
    end
  end

  // default-loaded registers, one instance each
  generate
    for (genvar g = 0; g < NDEF; g++) begin : gen_def
      logic wr_this;
      logic load_this;
      logic [REG_W-1:0] set_this;
      assign wr_this = wr_go & rct_hit(avs_address, DEF_IDX[g]);
      // resets load, wake loads data memory if only
      assign load_this = any_reset | (DEF_ON_WAKE[g] & any_wake);
      assign set_this = ((g == DEF_IRQ_SLOT) && cause[C_INT_WAKE]) ? wake_irq_flags : '0;
      rct_reset_reg #(
        .IMPL(DEF_IMPL[g]),
        .LMASK(DEF_LMASK[g]),
        .LVAL(DEF_LVAL[g])
      ) u_reg (
        .clock(clock),
        .rst(rst),
        .sw_write(wr_this),
        .sw_wdata(avs_writedata[REG_W-1:0]),
        .load(load_this),
        .set_bits(set_this),
        .q(def_q[g])
      );
    end
  endgenerate

  // free-running tick for the power-up timer
  always_ff @(posedge clock) begin
    if (rst || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));

  // power-up timer counts ticks only in its state
  always_ff @(posedge clock) begin
    if (rst || state != S_PUP_WAIT || supply_low_s) begin
      pup_cnt <= '0;
    end else if (tick) begin
      pup_cnt <= pup_cnt + 1'b1;
    end
  end

  // oscillator timer counts input oscillator edges
  always_ff @(posedge clock) begin
    if (rst || state != S_OSC_WAIT) begin
      osc_cnt <= '0;
    end else if (osc_edge) begin
      osc_cnt <= osc_cnt + 1'b1;
    end
  end

  // remembers which kind of hold is waiting for supply
  always_ff @(posedge clock) begin
    if (rst || cause[C_POR]) begin
      hold_is_dip <= 1'b0;
    end else if (cause[C_DIP]) begin
      hold_is_dip <= 1'b1;
    end
  end

  // start-up sequencer
  always_ff @(posedge clock) begin
    if (rst || cause[C_POR] || cause[C_DIP]) begin
      state <= S_HOLD;
    end else if (cause[C_CLR_RUN] || cause[C_CLR_SLEEP] || cause[C_DOG_RST]) begin
      state <= S_RELEASE;
    end else if (any_wake) begin
      state <= crystal ? S_OSC_WAIT : S_RELEASE;
    end else begin
      case (state)
        S_HOLD: begin
          if (!supply_low_s) begin
            if (hold_is_dip || !cfg[CFG_DLY_BIT]) begin
              state <= S_PUP_WAIT;
            end else begin
              state <= crystal ? S_OSC_WAIT : S_RELEASE;
            end
          end
        end
        S_PUP_WAIT: begin
          if (supply_low_s) begin
            state <= S_HOLD;
          end else if (tick && pup_cnt == DELAY_W'(DELAY_TICKS - 1)) begin
            state <= crystal ? S_OSC_WAIT : S_RELEASE;
          end
        end
        S_OSC_WAIT: begin
          if (osc_edge && osc_cnt == OSC_WAIT_W'(OSC_WAIT_CYCLES - 1)) begin
            state <= S_RELEASE;
          end
        end
        S_RELEASE: begin
          // start as soon as master clear is high
          if (clear_s) begin
            state <= S_RUN;
          end
        end
        S_RUN: begin
          // master clear low drops back to held release
          if (!clear_s) begin
            state <= S_RELEASE;
          end
        end
        default: begin
          state <= S_HOLD;
        end
      endcase
    end
  end

  // core held in reset until the sequencer runs
  always_ff @(posedge clock) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (state != S_RUN);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_load <= 1'b0;
      pc_load_value <= PC_RESET;
      vector_pending <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      if (any_reset) begin
        pc_load <= 1'b1;
        pc_load_value <= PC_RESET;
        vector_pending <= 1'b0;
      end else if (any_wake) begin
        pc_load <= 1'b1;
        pc_load_value <= pc_current + PC_STEP;
        vector_pending <= cause[C_INT_WAKE] & def_q[DEF_IRQ_SLOT][IRQ_EN_BIT];
      end else if (vector_pending && instr_step) begin
        // vector after the woken instruction completes
        pc_load <= 1'b1;
        pc_load_value <= PC_VECTOR;
        vector_pending <= 1'b0;
      end
    end
  end

endmodule : rct_reset_cause

/* dv/rct_reset_cause_checker.sv */
`timescale 1ns/1ps
module rct_reset_cause_checker
  import rct_pkg::*;
#(
  parameter int DELAY_TICKS = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rct_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [rct_pkg::CAUSE_W-1:0] cause_onehot,
  input wire logic [rct_pkg::PC_W-1:0] pc_current,
  input wire logic instr_step,
  input wire logic core_reset,
  input wire logic pc_load,
  input wire logic [rct_pkg::PC_W-1:0] pc_load_value,
  input wire logic vector_pending
);
  // shortest legal hold, the first tick may be partial
  localparam int LOW_BOUND = (DELAY_TICKS - 1) * TICK_CYCLES;
  logic [15:0] since_dip; // cycles since brown-out or reset
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // count from brown-out, park high on other causes
  always_ff @(posedge clock) begin
    if (rst || cause_onehot[C_DIP]) since_dip <= '0;
    else if (|cause_onehot) since_dip <= 16'hFFFF;
    else if (since_dip != 16'hFFFF) since_dip <= since_dip + 16'h0001;
  end
  a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("new request not held off");
  a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_read_zero_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_reset_pc_zero: assert property ((cause_onehot[C_POR] || cause_onehot[C_CLR_RUN] ||
    cause_onehot[C_CLR_SLEEP] || cause_onehot[C_DOG_RST]) |=> pc_load && pc_load_value == PC_RESET)
    else $error("reset did not load zero");
  a_wake_pc_step: assert property ((cause_onehot[C_DOG_WAKE] || cause_onehot[C_INT_WAKE]) && !cause_onehot[C_POR]
    |=> pc_load && pc_load_value == $past(pc_current) + PC_STEP)
    else $error("wake did not continue at next address");
  a_vector_load: assert property (vector_pending && instr_step |=> pc_load && pc_load_value == PC_VECTOR)
    else $error("vector not loaded after step");
  a_pc_load_cause: assert property (pc_load |-> $past(|cause_onehot) || $past(vector_pending && instr_step))
    else $error("program counter loaded without cause");
  a_por_holds_core: assert property (cause_onehot[C_POR] |-> ##2 core_reset [*2])
    else $error("core not held after power-on");
  a_delay_min_hold: assert property ($fell(core_reset) |-> since_dip > LOW_BOUND)
    else $error("core released before power-up delay");
endmodule : rct_reset_cause_checker

bind rct_reset_cause rct_reset_cause_checker #(.DELAY_TICKS(DELAY_TICKS)) u_checker (
  .clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cause_onehot(cause_onehot), .pc_current(pc_current),
  .instr_step(instr_step), .core_reset(core_reset), .pc_load(pc_load), .pc_load_value(pc_load_value),
  .vector_pending(vector_pending)
);

/* dv/rct_reset_cause_tb.sv */
`timescale 1ns/1ps
module rct_reset_cause_tb;
  import rct_pkg::*;
  localparam int PT = 4; // shortened power-up tick count
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [CAUSE_W-1:0] cause_onehot = '0;
  logic [REG_W-1:0] wake_irq_flags = '0;
  logic [PC_W-1:0] pc_current = '0;
  logic instr_step = 1'b0;
  logic master_clear_n = 1'b1;
  logic supply_low = 1'b1;
  logic osc_clk_in = 1'b0;
  logic core_reset, pc_load, vector_pending, wake;
  logic [PC_W-1:0] pc_load_value;
  logic [1:0] osc_div = '0;
  logic [7:0] st, pm, ic, op, ee, r; // register models
  logic [31:0] q;
  int fails = 0;
  int n_compared = 0;
  int seed = 4;
  int n, k, lo;
  logic [7:0] r_idx [12] = '{8'h03, 8'h8E, 8'hC0, 8'h0B, 8'h81, 8'h85, 8'h86, 8'h0A, 8'h1F, 8'h9F, 8'h90, 8'h40};
  logic [7:0] r_exp [12] = '{8'h18, 8'h00, 8'h09, 8'h00, 8'hFF, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
  logic [7:0] t_cfg [6] = '{8'h09, 8'h0D, 8'h0B, 8'h0F, 8'h09, 8'h0B};
  int t_cause [6] = '{C_DIP, C_POR, C_POR, C_POR, C_DOG_WAKE, C_DOG_WAKE};

  rct_reset_cause #(.DELAY_TICKS(PT)) u_rct_reset_cause (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cause_onehot(cause_onehot), .wake_irq_flags(wake_irq_flags),
    .pc_current(pc_current), .instr_step(instr_step), .master_clear_n(master_clear_n),
    .supply_low(supply_low), .osc_clk_in(osc_clk_in), .core_reset(core_reset), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .vector_pending(vector_pending)
  );

  initial begin
    forever #5 clock = ~clock;
  end
  // oscillator input at a quarter of the clock rate
  always @(posedge clock) begin
    osc_div <= osc_div + 2'h1;
    osc_clk_in <= osc_div[1];
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // one bus cycle, held until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be, input logic [1:0] lo2);
    int w;
    @(posedge clock);
    avs_address <= {idx, lo2};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    w = 0;
    // values read right after the edge are those sampled at it
    do begin
      @(posedge clock);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 20);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      close_out();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF, 2'b00);
  endtask : wr

  task rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hF, 2'b00);
    check(what, q, {24'h0, exp});
  endtask : rd

  task pulse(input int c);
    @(posedge clock);
    cause_onehot <= 7'h01 << c;
    @(posedge clock);
    cause_onehot <= '0;
    repeat (3) @(posedge clock);
  endtask : pulse

  // cycles until the core leaves reset, bounded
  task wait_run;
    n = 0;
    while (core_reset !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      close_out();
    end
  endtask : wait_run

  function int lo_bound(input logic [7:0] cfg, input int c);
    int pw, os;
    pw = ((c == C_POR && !cfg[2]) || c == C_DIP) ? (PT - 1) * TICK_CYCLES : 0;
    os = (cfg[1:0] != 2'b11) ? 4 * 1020 : 0;
    return pw + os;
  endfunction : lo_bound

  function logic [7:0] exp_status(input int c, input logic [7:0] o);
    case (c)
      C_POR: return {5'b00011, o[2:0]};
      C_DIP: return {5'b00011, o[2:0]};
      C_CLR_RUN: return {3'b000, o[4:0]};
      C_CLR_SLEEP: return {5'b00010, o[2:0]};
      C_DOG_RST: return {5'b00001, o[2:0]};
      C_DOG_WAKE: return {o[7:5], 2'b00, o[2:0]};
      default: return {o[7:5], 2'b10, o[2:0]};
    endcase
  endfunction : exp_status

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) rd("reset value", r_idx[i], r_exp[i]);
    bus(1'b0, 8'h03, 8'h00, 4'hF, 2'b01);
    check("misaligned read", q, 32'h0);
    wr(8'h8E, 8'hFF);
    rd("power cause upper", 8'h8E, 8'h03);
    wr(8'h9F, 8'hFF);
    rd("vrcon gap", 8'h9F, 8'hEF);
    bus(1'b1, 8'h81, 8'h12, 4'h0, 2'b00);
    rd("option kept", 8'h81, 8'hFF);
    // power-up with a supply dip inside the timer
    supply_low <= 1'b0;
    repeat (200) @(posedge clock);
    supply_low <= 1'b1;
    repeat (10) @(posedge clock);
    supply_low <= 1'b0;
    wait_run();
    lo = lo_bound(8'h09, C_DIP);
    check("power-up hold", n >= lo && n <= lo + 300, 1);
    st = 8'h18;
    // every cause over random prior contents
    for (int j = 0; j < 7; j++) begin
      k = (j + 2) % 7;
      r = $random(seed);
      wr(8'h03, r);
      st = (r & 8'hE7) | (st & 8'h18);
      wr(8'h8E, 8'h03);
      pm = 8'h03;
      r = $random(seed);
      ic = r & 8'h7F;
      wr(8'h0B, ic);
      op = $random(seed);
      wr(8'h81, op);
      ee = $random(seed);
      wr(8'h90, ee);
      pc_current <= $random(seed);
      wake_irq_flags <= $random(seed);
      pulse(k);
      st = exp_status(k, st);
      if (k == C_POR) pm[1] = 1'b0;
      if (k == C_DIP) pm[0] = 1'b0;
      wake = (k == C_DOG_WAKE || k == C_INT_WAKE);
      if (k == C_INT_WAKE) ic = ic | wake_irq_flags;
      else if (!wake) begin
        ic = {7'h0, ic[0]};
        op = 8'hFF;
      end
      rd("status", 8'h03, st);
      rd("power cause", 8'h8E, pm);
      rd("intcon", 8'h0B, ic);
      rd("option", 8'h81, op);
      rd("data mem if", 8'h90, ee | 8'h07);
      check("pc load", pc_load_value, wake ? 13'(pc_current + 13'h1) : 13'h0);
      wait_run();
    end
    // interrupt wake with global enable
    wr(8'h0B, 8'h80);
    pulse(C_INT_WAKE);
    wait_run();
    check("vector pending", vector_pending, 1'b1);
    instr_step <= 1'b1;
    @(posedge clock);
    instr_step <= 1'b0;
    repeat (2) @(posedge clock);
    check("vector", pc_load_value, 13'h0004);
    check("vector done", vector_pending, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(8'hC0, t_cfg[i]);
      pulse(t_cause[i]);
      wait_run();
      lo = lo_bound(t_cfg[i], t_cause[i]);
      check("start-up delay", n >= lo && n <= lo + 300, 1);
    end
    // master clear held through the time-outs
    wr(8'hC0, 8'h09);
    master_clear_n <= 1'b0;
    pulse(C_POR);
    repeat (lo_bound(8'h09, C_POR) + 500) @(posedge clock);
    check("held by master clear", core_reset, 1'b1);
    master_clear_n <= 1'b1;
    wait_run();
    check("prompt start", n <= 10, 1);
    close_out();
  end
endmodule : rct_reset_cause_tb
